// file: rtl/dsw_data_decode.v
// Data-space decoder with read-only program memory window
`timescale 1ns/1ps
`include "dsw_map.vh"
module dsw_data_decode #(
  parameter PROG_AW = `DSW_PC_W
) (
  input wire sys_clk,
  input wire nrst,
  input wire [7:0] dataAddr,
  input wire [7:0] dataWrData,
  input wire dataWrEn,
  input wire dataRdEn,
  output reg [7:0] dataRdData,
  output reg [3:0] accessSel,
  output reg [7:0] periAddr,
  output reg [7:0] periWrData,
  output reg periWrEn,
  output reg periRdEn,
  input wire [7:0] periRdData,
  output reg [PROG_AW-1:0] progRdAddr,
  output reg progRdEn,
  input wire [7:0] progRdData,
  output reg bankRamSel,
  output reg bankEeSel,
  input wire [7:0] eeRdData,
  input wire nmiIn,
  output reg nmiReq,
  input wire readoutProtect,
  input wire extProgRdReq,
  input wire [PROG_AW-1:0] extProgRdAddr,
  output reg extProgRdGrant,
  input wire artimerAltEn,
  input wire artimerOut,
  input wire [7:0] portBOut,
  output reg [7:0] portBPin,
  output reg timerAltInput,
  input wire [7:0] portBIn,
  input wire callPush,
  input wire retPop,
  input wire [PROG_AW-1:0] pcIn,
  output reg [PROG_AW-1:0] retAddr
);
  // Data-space region decode shared by read and write path
  function [3:0] region;
    input [7:0] a;
    begin
      if (a <= `DSW_BANK_HI) begin
        region = `DSW_SEL_BANK;
      end else if (a >= `DSW_WIN_LO && a <= `DSW_WIN_HI) begin
        region = `DSW_SEL_WIN;
      end else if (a >= `DSW_CORE_LO && a <= `DSW_CORE_HI) begin
        region = `DSW_SEL_CORE;
      end else if (a >= `DSW_RAM_LO && a <= `DSW_RAM_HI) begin
        region = `DSW_SEL_RAM;
      end else if ((a >= `DSW_PDATA_LO && a <= `DSW_PDATA_HI) ||
          (a >= `DSW_PDIR_LO && a <= `DSW_PDIR_HI) ||
          (a >= `DSW_POPT_LO && a <= `DSW_POPT_HI) || a == `DSW_INTOPT) begin
        region = `DSW_SEL_PORT;
      end else if (a >= `DSW_PERI_LO && a <= `DSW_PERI_HI) begin
        region = `DSW_SEL_PERI;
      end else if (a == `DSW_WIN_BASE || a == `DSW_BANK_SEL || a == `DSW_EECTL ||
          a == `DSW_ACC) begin
        region = `DSW_SEL_CTRL;
      end else begin
        region = `DSW_SEL_NONE;
      end
    end
  endfunction

  wire [3:0] sel;
  assign sel = region(dataAddr);

  // Window base: no reset on purpose, contents undefined until written
  reg [`DSW_WIN_BASE_W-1:0] romWindowUpperBits;
  always @(posedge sys_clk) begin
    if (dataWrEn && dataAddr == `DSW_WIN_BASE) begin
      romWindowUpperBits <= dataWrData[`DSW_WIN_BASE_W-1:0];
    end
  end

  // Bank select also unreset, write-only
  reg [7:0] bankSelectReg;
  always @(posedge sys_clk) begin
    if (dataWrEn && dataAddr == `DSW_BANK_SEL) begin
      bankSelectReg <= dataWrData;
    end
  end

  // Window address: base above offset, aligned 64-byte blocks
  wire [PROG_AW-1:0] winAddr;
  assign winAddr = {romWindowUpperBits,
    dataAddr[`DSW_WIN_OFS_W-1:0]};

  // Extra RAM page 2
  wire ramWe;
  wire [7:0] ram2Rd;
  wire [7:0] gpRd;
  wire gpWe;
  wire [5:0] gpAddr;
  assign ramWe = dataWrEn && sel == `DSW_SEL_BANK &&
    bankSelectReg[`DSW_SEL_RAM2_BIT] && !bankSelectReg[`DSW_SEL_EE0_BIT];
  assign gpWe = dataWrEn && (sel == `DSW_SEL_RAM || sel == `DSW_SEL_CORE ||
    dataAddr == `DSW_ACC);
  assign gpAddr = (dataAddr == `DSW_ACC) ? 6'h3f : dataAddr[5:0] ^ 6'h00;

  dsw_sync_ram #(.AW(6), .DW(8)) uRamPage2 (
    .sys_clk(sys_clk),
    .we(ramWe),
    .wrAddr(dataAddr[5:0]),
    .wrData(dataWrData),
    .rdAddr(dataAddr[5:0]),
    .rdData(ram2Rd)
  );

  // Core registers and general RAM share one array; accumulator in slot 3Fh
  // would clash with BFh, so the accumulator is held apart below
  reg [7:0] accReg;
  dsw_sync_ram #(.AW(6), .DW(8)) uRamMain (
    .sys_clk(sys_clk),
    .we(gpWe && dataAddr != `DSW_ACC),
    .wrAddr(gpAddr),
    .wrData(dataWrData),
    .rdAddr(gpAddr),
    .rdData(gpRd)
  );

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      accReg <= 8'h00;
    end else if (dataWrEn && dataAddr == `DSW_ACC) begin
      accReg <= dataWrData;
    end
  end

  // Return stack kept out of data space
  wire [PROG_AW-1:0] stackTop;
  dsw_ret_stack #(.DEPTH(`DSW_STACK_DEPTH), .PW(PROG_AW)) uStack (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .push(callPush),
    .pop(retPop),
    .pushAddr(pcIn),
    .topAddr(stackTop)
  );

  // Read source captured for the cycle the memories answer
  reg [3:0] rdSelQ;
  reg [7:0] rdAddrQ;
  reg rdPendQ;
  reg [1:0] bankQ;
  reg nmiPrev;
  reg [7:0] next_rdData;

  always @* begin
    case (rdSelQ)
      `DSW_SEL_BANK: begin
        if (bankQ == 2'b10) begin
          next_rdData = ram2Rd;
        end else if (bankQ == 2'b01) begin
          next_rdData = eeRdData;
        end else begin
          next_rdData = `DSW_RD_DEFAULT;
        end
      end
      `DSW_SEL_WIN: next_rdData = progRdData;
      `DSW_SEL_CORE, `DSW_SEL_RAM: next_rdData = gpRd;
      `DSW_SEL_PORT, `DSW_SEL_PERI: next_rdData = periRdData;
      `DSW_SEL_CTRL: begin
        // Write-only registers read back a fixed pattern
        if (rdAddrQ == `DSW_ACC) begin
          next_rdData = accReg;
        end else if (rdAddrQ == `DSW_EECTL) begin
          next_rdData = periRdData;
        end else begin
          next_rdData = `DSW_RD_DEFAULT;
        end
      end
      default: next_rdData = `DSW_RD_DEFAULT;
    endcase
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dataRdData <= 8'h00;
      accessSel <= 4'h0;
      periAddr <= 8'h00;
      periWrData <= 8'h00;
      periWrEn <= 1'b0;
      periRdEn <= 1'b0;
      progRdAddr <= {PROG_AW{1'b0}};
      progRdEn <= 1'b0;
      bankRamSel <= 1'b0;
      bankEeSel <= 1'b0;
      nmiReq <= 1'b0;
      nmiPrev <= 1'b1;
      extProgRdGrant <= 1'b0;
      portBPin <= 8'h00;
      timerAltInput <= 1'b0;
      retAddr <= {PROG_AW{1'b0}};
      rdSelQ <= 4'h0;
      rdAddrQ <= 8'h00;
      rdPendQ <= 1'b0;
      bankQ <= 2'b00;
    end else begin
      accessSel <= (dataRdEn || dataWrEn) ? sel : `DSW_SEL_NONE;
      periAddr <= dataAddr;
      periWrData <= dataWrData;
      // Window writes never reach program memory or peripherals
      periWrEn <= dataWrEn && (sel == `DSW_SEL_PORT || sel == `DSW_SEL_PERI ||
        dataAddr == `DSW_EECTL ||
        (sel == `DSW_SEL_BANK && bankSelectReg[`DSW_SEL_EE0_BIT]));
      periRdEn <= dataRdEn && (sel == `DSW_SEL_PORT || sel == `DSW_SEL_PERI ||
        dataAddr == `DSW_EECTL ||
        (sel == `DSW_SEL_BANK && bankSelectReg[`DSW_SEL_EE0_BIT]));
      // Core reads take priority; external readout only when unprotected
      if (dataRdEn && sel == `DSW_SEL_WIN) begin
        progRdAddr <= winAddr;
        progRdEn <= 1'b1;
        extProgRdGrant <= 1'b0;
      end else if (extProgRdReq && !readoutProtect) begin
        progRdAddr <= extProgRdAddr;
        progRdEn <= 1'b1;
        extProgRdGrant <= 1'b1;
      end else begin
        progRdEn <= 1'b0;
        extProgRdGrant <= 1'b0;
      end
      bankRamSel <= bankSelectReg[`DSW_SEL_RAM2_BIT];
      bankEeSel <= bankSelectReg[`DSW_SEL_EE0_BIT];
      rdPendQ <= dataRdEn;
      rdSelQ <= sel;
      rdAddrQ <= dataAddr;
      bankQ <= {bankSelectReg[`DSW_SEL_RAM2_BIT], bankSelectReg[`DSW_SEL_EE0_BIT]};
      if (rdPendQ) begin
        dataRdData <= next_rdData;
      end
      nmiPrev <= nmiIn;
      nmiReq <= nmiPrev && !nmiIn;
      // PB6 input and PB7 output swap to the timer when enabled
      portBPin <= artimerAltEn ? {artimerOut, portBOut[6:0]} : portBOut;
      timerAltInput <= artimerAltEn & portBIn[6];
      retAddr <= stackTop;
    end
  end
endmodule // dsw_data_decode

// file: rtl/dsw_map.vh
// Address map, field positions and reset values of the data-space decoder
`ifndef DSW_MAP_VH
`define DSW_MAP_VH
`define DSW_BANK_LO 8'h00
`define DSW_BANK_HI 8'h3f
`define DSW_WIN_LO 8'h40
`define DSW_WIN_HI 8'h7f
`define DSW_CORE_LO 8'h80
`define DSW_CORE_HI 8'h83
`define DSW_RAM_LO 8'h84
`define DSW_RAM_HI 8'hbf
`define DSW_PDATA_LO 8'hc0
`define DSW_PDATA_HI 8'hc2
`define DSW_PDIR_LO 8'hc4
`define DSW_PDIR_HI 8'hc6
`define DSW_INTOPT 8'hc8
`define DSW_WIN_BASE 8'hc9
`define DSW_POPT_LO 8'hcc
`define DSW_POPT_HI 8'hce
`define DSW_PERI_LO 8'hd0
`define DSW_PERI_HI 8'hdb
`define DSW_ART_LO 8'hd5
`define DSW_BANK_SEL 8'he8
`define DSW_EECTL 8'hea
`define DSW_ACC 8'hff
`define DSW_WIN_OFS_W 6
`define DSW_WIN_BASE_W 6
`define DSW_SEL_RAM2_BIT 4
`define DSW_SEL_EE0_BIT 0
`define DSW_PC_W 12
`define DSW_STACK_DEPTH 6
`define DSW_PC_RESET 12'h000
`define DSW_RD_DEFAULT 8'hff
`define DSW_REG_ARB 8'h00
`define DSW_T_REG_ARB 8'h00
`define DSW_SEL_NONE 4'h0
`define DSW_SEL_BANK 4'h1
`define DSW_SEL_WIN 4'h2
`define DSW_SEL_CORE 4'h3
`define DSW_SEL_RAM 4'h4
`define DSW_SEL_PORT 4'h5
`define DSW_SEL_PERI 4'h6
`define DSW_SEL_CTRL 4'h7
`endif

// file: rtl/dsw_ret_stack.v
// Return-address stack held apart from data space
`timescale 1ns/1ps
`include "dsw_map.vh"
module dsw_ret_stack #(
  parameter DEPTH = `DSW_STACK_DEPTH,
  parameter PW = `DSW_PC_W
) (
  input wire sys_clk,
  input wire nrst,
  input wire push,
  input wire pop,
  input wire [PW-1:0] pushAddr,
  output reg [PW-1:0] topAddr
);
  reg [PW-1:0] entry [0:DEPTH-1];
  integer i;
  // Overflow drops the oldest entry, as the core has no stack pointer check
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        entry[i] <= {PW{1'b0}};
      end
      topAddr <= {PW{1'b0}};
    end else if (push) begin
      entry[0] <= pushAddr;
      for (i = 1; i < DEPTH; i = i + 1) begin
        entry[i] <= entry[i-1];
      end
      topAddr <= pushAddr;
    end else if (pop) begin
      for (i = 0; i < DEPTH - 1; i = i + 1) begin
        entry[i] <= entry[i+1];
      end
      entry[DEPTH-1] <= {PW{1'b0}};
      topAddr <= entry[1];
    end
  end
endmodule // dsw_ret_stack

// file: rtl/dsw_sync_ram.v
// Small synchronous memory with registered read data
`timescale 1ns/1ps
module dsw_sync_ram #(
  parameter AW = 6,
  parameter DW = 8
) (
  input wire sys_clk,
  input wire we,
  input wire [AW-1:0] wrAddr,
  input wire [DW-1:0] wrData,
  input wire [AW-1:0] rdAddr,
  output reg [DW-1:0] rdData
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge sys_clk) begin
    if (we) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // dsw_sync_ram

// file: tb/dsw_core_model.sv
// Program memory and peripheral responder beside the decoder
`timescale 1ns/1ps
module dsw_core_model (
  input wire [11:0] progRdAddr,
  input wire progRdEn,
  input wire [7:0] periAddr,
  output wire [7:0] progRdData,
  output wire [7:0] periRdData,
  output wire [7:0] eeRdData
);
  // Block bits mixed in so a wrong base shows
  wire [7:0] romByte = progRdAddr[7:0] ^ {progRdAddr[11:6], 2'b01};
  // Outside a fetch the bus shows the inverse, never a held value
  assign progRdData = progRdEn ? romByte : ~romByte;
  assign periRdData = ~periAddr;
  assign eeRdData = 8'h3c;
endmodule // dsw_core_model

// file: tb/dsw_data_decode_assertions.sv
// Port checker for the data-space decoder
`timescale 1ns/1ps
module dsw_decode_chk #(
  parameter PROG_AW = 12
) (
  input wire sys_clk,
  input wire nrst,
  input wire [7:0] dataAddr,
  input wire [7:0] dataWrData,
  input wire dataWrEn,
  input wire dataRdEn,
  input wire [7:0] dataRdData,
  input wire [3:0] accessSel,
  input wire periWrEn,
  input wire periRdEn,
  input wire [7:0] periAddr,
  input wire [7:0] periWrData,
  input wire [PROG_AW-1:0] progRdAddr,
  input wire progRdEn,
  input wire [7:0] progRdData,
  input wire bankRamSel,
  input wire bankEeSel,
  input wire nmiIn,
  input wire nmiReq,
  input wire readoutProtect,
  input wire extProgRdGrant,
  input wire callPush,
  input wire [PROG_AW-1:0] pcIn,
  input wire [PROG_AW-1:0] retAddr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire winHit = dataAddr[7:6] == 2'b01;
  AST_WIN_ADDR: assert property (dataRdEn && winHit |=> progRdEn && accessSel == 4'h2
    && progRdAddr[5:0] == $past(dataAddr[5:0])) else $error("window fetch address wrong");
  AST_WIN_DATA: assert property (progRdEn && accessSel == 4'h2
    |=> dataRdData == $past(progRdData)) else $error("window data not returned");
  AST_WIN_NOWR: assert property (dataWrEn && winHit |=> !periWrEn)
    else $error("window write leaked");
  AST_WIN_BASE: assert property (dataWrEn && dataAddr == 8'hc9 ##2 dataRdEn && winHit
    |=> progRdAddr[11:6] == $past(dataWrData[5:0], 3)) else $error("window block wrong");
  // Answer stands from the second edge; a later read may replace it
  AST_NO_READ: assert property (dataRdEn && dataAddr == 8'hc9
    |-> ##2 dataRdData == 8'hff) else $error("base readback not ff");
  AST_BANK: assert property (dataWrEn && dataAddr == 8'he8 |-> ##2
    bankRamSel == $past(dataWrData[4], 2) && bankEeSel == $past(dataWrData[0], 2))
    else $error("bank select wrong");
  AST_NMI: assert property ($fell(nmiIn) |-> ##[1:2] nmiReq)
    else $error("nmi missed");
  AST_NMI_ONE: assert property (nmiReq |=> !nmiReq)
    else $error("nmi too long");
  AST_PROTECT: assert property (readoutProtect && $past(readoutProtect) |-> !extProgRdGrant)
    else $error("protected readout granted");
  AST_STACK: assert property (callPush |-> ##2 retAddr == $past(pcIn, 2))
    else $error("stack top wrong");
  AST_PERI_RD: assert property (dataRdEn && dataAddr >= 8'hd0 && dataAddr <= 8'hdb
    |=> periRdEn && periAddr == $past(dataAddr)) else $error("peripheral read not forwarded");
  AST_PERI_WR: assert property (dataWrEn && dataAddr >= 8'hd0 && dataAddr <= 8'hdb
    |=> periWrEn && periWrData == $past(dataWrData)) else $error("peripheral write lost");
endmodule // dsw_decode_chk
bind dsw_data_decode dsw_decode_chk #(.PROG_AW(PROG_AW)) chk (.sys_clk(sys_clk), .nrst(nrst),
  .dataAddr(dataAddr), .dataWrData(dataWrData), .dataWrEn(dataWrEn), .dataRdEn(dataRdEn),
  .dataRdData(dataRdData), .accessSel(accessSel), .periWrEn(periWrEn), .periRdEn(periRdEn),
  .periAddr(periAddr), .periWrData(periWrData), .progRdAddr(progRdAddr),
  .progRdEn(progRdEn), .progRdData(progRdData), .bankRamSel(bankRamSel),
  .bankEeSel(bankEeSel), .nmiIn(nmiIn), .nmiReq(nmiReq), .readoutProtect(readoutProtect),
  .extProgRdGrant(extProgRdGrant), .callPush(callPush), .pcIn(pcIn), .retAddr(retAddr));

// file: tb/dsw_data_decode_bench.sv
// Self-checking bench for the data-space decoder
`timescale 1ns/1ps
module dsw_data_decode_bench;
  logic sys_clk = '0, nrst = '0, dataWrEn = '0, dataRdEn = '0, nmiIn = 1'b1, hit = '0;
  logic readoutProtect = '0, extProgRdReq = '0, callPush = '0, retPop = '0;
  logic artimerAltEn = '0, artimerOut = '0;
  logic [7:0] dataAddr = '0, dataWrData = '0, portBOut = '0, portBIn = '0;
  logic [11:0] extProgRdAddr = 12'h345, pcIn = '0;
  logic [7:0] bases [3] = '{8'h00, 8'hff, 8'h85};
  wire [7:0] dataRdData, progRdData, periRdData, eeRdData, periAddr, periWrData, portBPin;
  wire [11:0] progRdAddr, retAddr;
  wire progRdEn, nmiReq, extProgRdGrant, bankRamSel, bankEeSel, timerAltInput;
  int fails = 0, checks = 0;
  dsw_data_decode dut (.sys_clk(sys_clk), .nrst(nrst), .dataAddr(dataAddr),
    .dataWrData(dataWrData), .dataWrEn(dataWrEn), .dataRdEn(dataRdEn),
    .dataRdData(dataRdData), .accessSel(), .periAddr(periAddr), .periWrData(periWrData),
    .periWrEn(), .periRdEn(), .periRdData(periRdData), .progRdAddr(progRdAddr),
    .progRdEn(progRdEn), .progRdData(progRdData), .bankRamSel(bankRamSel),
    .bankEeSel(bankEeSel), .eeRdData(eeRdData), .nmiIn(nmiIn), .nmiReq(nmiReq),
    .readoutProtect(readoutProtect), .extProgRdReq(extProgRdReq),
    .extProgRdAddr(extProgRdAddr), .extProgRdGrant(extProgRdGrant),
    .artimerAltEn(artimerAltEn), .artimerOut(artimerOut), .portBOut(portBOut),
    .portBPin(portBPin), .timerAltInput(timerAltInput), .portBIn(portBIn),
    .callPush(callPush), .retPop(retPop), .pcIn(pcIn), .retAddr(retAddr));
  dsw_core_model partner (.progRdAddr(progRdAddr), .progRdEn(progRdEn), .periAddr(periAddr),
    .progRdData(progRdData), .periRdData(periRdData), .eeRdData(eeRdData));
  initial forever #12.5 sys_clk = ~sys_clk;
  function automatic logic [7:0] rom(input logic [11:0] a);
    return a[7:0] ^ {a[11:6], 2'b01};
  endfunction
  task automatic chk(input string what, input logic [11:0] exp, got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge sys_clk);
    dataAddr = a;
    dataWrData = d;
    dataWrEn = 1'b1;
    @(negedge sys_clk);
    dataWrEn = 1'b0;
  endtask
  // Answer lands two edges after the request
  task automatic rd(input logic [7:0] a, exp, input string what);
    @(negedge sys_clk);
    dataAddr = a;
    dataRdEn = 1'b1;
    @(negedge sys_clk);
    dataRdEn = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(what, {4'h0, exp}, {4'h0, dataRdData});
  endtask
  task automatic stk(input logic psh, pp, input logic [11:0] pc, exp);
    @(negedge sys_clk);
    callPush = psh;
    retPop = pp;
    pcIn = pc;
    @(negedge sys_clk);
    callPush = 1'b0;
    retPop = 1'b0;
    @(negedge sys_clk);
    chk("return address", exp, retAddr);
  endtask
  task automatic ext(input logic prot, exp);
    @(negedge sys_clk);
    readoutProtect = prot;
    extProgRdReq = 1'b1;
    hit = 1'b0;
    repeat (3) begin
      @(negedge sys_clk);
      hit |= extProgRdGrant;
    end
    extProgRdReq = 1'b0;
    chk("readout grant", {11'h0, exp}, {11'h0, hit});
  endtask
  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge sys_clk);
    nrst = 1'b1;
    foreach (bases[i]) begin
      // Image first, so an interrupt between the two writes sees a valid copy
      wr(8'hbe, bases[i]);
      wr(8'hc9, bases[i]);
      rd(8'h40, rom({bases[i][5:0], 6'h00}), "window low");
      rd(8'h7f, rom({bases[i][5:0], 6'h3f}), "window high");
    end
    rd(8'hbe, 8'h85, "base image");
    wr(8'h55, 8'h00);
    rd(8'h55, rom({6'h05, 6'h15}), "window after write");
    rd(8'hc9, 8'hff, "base readback");
    rd(8'h41, rom({6'h05, 6'h01}), "window after readback");
    rd(8'hc3, 8'hff, "reserved");
    rd(8'hc1, 8'h3e, "port data");
    wr(8'hd5, 8'h3a);
    chk("peripheral write data", 12'h03a, {4'h0, periWrData});
    rd(8'hd5, 8'h2a, "timer register");
    wr(8'h84, 8'h9e);
    rd(8'h84, 8'h9e, "ram byte");
    wr(8'he8, 8'h01);
    @(negedge sys_clk);
    chk("bank select", 12'h1, {10'h0, bankRamSel, bankEeSel});
    rd(8'h10, 8'h3c, "eeprom page");
    wr(8'he8, 8'h10);
    @(negedge sys_clk);
    chk("bank select", 12'h2, {10'h0, bankRamSel, bankEeSel});
    wr(8'h10, 8'h77);
    rd(8'h10, 8'h77, "ram page");
    nmiIn = 1'b0;
    hit = 1'b0;
    repeat (3) begin
      @(negedge sys_clk);
      hit |= nmiReq;
    end
    chk("nmi request", 12'h1, {11'h0, hit});
    nmiIn = 1'b1;
    artimerAltEn = 1'b1;
    artimerOut = 1'b1;
    portBOut = 8'h15;
    portBIn = 8'h40;
    @(negedge sys_clk);
    chk("port b pins", 12'h095, {4'h0, portBPin});
    chk("timer input", 12'h1, {11'h0, timerAltInput});
    artimerAltEn = 1'b0;
    portBOut = 8'ha5;
    @(negedge sys_clk);
    chk("port b pins", 12'h0a5, {4'h0, portBPin});
    chk("timer input", 12'h0, {11'h0, timerAltInput});
    // Seven pushes overrun six entries; oldest is lost
    for (int i = 1; i < 8; i++) stk(1'b1, 1'b0, 12'h100 + 12'(i), 12'h100 + 12'(i));
    for (int i = 6; i > 1; i--) stk(1'b0, 1'b1, 12'h0, 12'h100 + 12'(i));
    ext(1'b0, 1'b1);
    chk("readout address", 12'h345, progRdAddr);
    ext(1'b1, 1'b0);
    nrst = 1'b0;
    @(negedge sys_clk);
    chk("return address in reset", 12'h0, retAddr);
    nrst = 1'b1;
    close_out();
  end
  initial begin
    #1000000;
    fails++;
    close_out();
  end
endmodule // dsw_data_decode_bench
